// file: core/spireg_params.svh
// constants of the serial register port
`ifndef SPIREG_PARAMS_SVH
`define SPIREG_PARAMS_SVH
`define SPIREG_CMD_WR 8'h0A
`define SPIREG_CMD_RD 8'h0B
`define SPIREG_CMD_FIFO 8'h0D
`define SPIREG_NREG 128
`define SPIREG_USER_LAST 7'h45
`define SPIREG_PROT_BITS 544
`define SPIREG_CHK_W 99
`define SPIREG_CHK_FOLD 49
`define SPIREG_PROT_LAST 7'h43
`define SPIREG_STAT_A 7'h0B
`define SPIREG_STAT_B 7'h44
`define SPIREG_ERR_BIT 7
`define SPIREG_BIT_LAST 3'h7
`endif

// file: core/spireg_pkg.sv
// types shared by the serial register port
package spireg_pkg;
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_FIFO, ST_IGNORE
  } spireg_state_t;
endpackage

// file: core/spireg_port.sv
// serial register port: command decode, bursts, fifo streaming, upset check
`include "spireg_params.svh"
module spireg_port (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [15:0] fifo_data,
  input wire logic fifo_valid,
  output logic fifo_pop,
  input wire logic seu_inject,
  input wire logic [9:0] seu_bit,
  output logic reg_err
);
  import spireg_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [2:0] sclk_q;
  logic [1:0] cs_q;
  logic [1:0] mosi_q;

  // two flops per pin, third sclk flop only for edges
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 3'h0;
      cs_q <= 2'h3;
      mosi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk};
      cs_q <= {cs_q[0], cs_n};
      mosi_q <= {mosi_q[0], mosi};
    end
  end

  wire cs_hi = cs_q[1];
  wire sclk_rise = sclk_q[1] & ~sclk_q[2] & ~cs_hi;
  wire sclk_fall = ~sclk_q[1] & sclk_q[2] & ~cs_hi;

  // ---------------------------------------------------------------
  // state and storage
  // ---------------------------------------------------------------
  spireg_state_t st_r;
  logic [2:0] cnt_r;
  logic [6:0] rx_r;
  logic [7:0] tx_r;
  logic [6:0] addr_r;
  logic [7:0] samp_r;
  logic half_r;
  logic [7:0] mem [`SPIREG_NREG];
  logic [`SPIREG_CHK_W-1:0] chk_r;
  logic cmd_wr_r;
  logic upd_r;
  spireg_state_t st_nxt;
  logic [`SPIREG_PROT_BITS-1:0] prot;

  // check code: folded column and row parity plus overall parity
  function automatic logic [`SPIREG_CHK_W-1:0] chk_calc(
    input logic [`SPIREG_PROT_BITS-1:0] v);
    logic [`SPIREG_CHK_W-1:0] c;
    c = '0;
    for (int i = 0; i < `SPIREG_PROT_BITS; i++) begin
      c[i % `SPIREG_CHK_FOLD] ^= v[i];
      c[`SPIREG_CHK_FOLD + i / `SPIREG_CHK_FOLD] ^= v[i];
      c[`SPIREG_CHK_W-1] ^= v[i];
    end
    return c;
  endfunction

  // register read value with status flag overlay
  function automatic logic [7:0] rd_byte(input logic [6:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == `SPIREG_STAT_A || a == `SPIREG_STAT_B) begin
      d = mem[a];
      d[`SPIREG_ERR_BIT] = reg_err;
    end else if (a <= `SPIREG_USER_LAST) begin
      d = mem[a];
    end
    return d;
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire byte_done = sclk_rise && (cnt_r == `SPIREG_BIT_LAST);
  wire [7:0] rx_byte = {rx_r, mosi_q[1]};
  wire [6:0] rx_addr = rx_byte[6:0];
  wire [6:0] addr_inc = addr_r + 7'h01;
  wire is_wr = rx_byte == `SPIREG_CMD_WR;
  wire is_rd = rx_byte == `SPIREG_CMD_RD;
  wire is_fifo = rx_byte == `SPIREG_CMD_FIFO;
  // frame events and what to send next
  wire cmd_done = byte_done && (st_r == ST_CMD);
  wire addr_done = byte_done && (st_r == ST_ADDR);
  wire wr_data = byte_done && (st_r == ST_WDATA);
  wire rd_next = byte_done && (st_r == ST_RDATA);
  wire data_done = wr_data || rd_next;
  wire wr_en = wr_data && (addr_r <= `SPIREG_USER_LAST);
  wire rd_load = (addr_done && !cmd_wr_r) || rd_next;
  wire [6:0] rd_addr = addr_done ? rx_addr : addr_inc;
  wire [7:0] rd_val = rd_byte(rd_addr);
  wire fifo_load = (cmd_done && is_fifo)
                   || (byte_done && (st_r == ST_FIFO) && !half_r);
  wire fifo_lo = byte_done && (st_r == ST_FIFO) && half_r;
  wire [15:0] fifo_word = fifo_valid ? fifo_data : 16'h0000;
  wire tx_load = rd_load || fifo_load || fifo_lo;
  wire [7:0] tx_val = rd_load ? rd_val
                      : (fifo_load ? fifo_word[15:8] : samp_r);
  wire shift_ok = sclk_fall && (cnt_r != 3'h0) && miso_oe;
  wire seu_ok = seu_inject && (seu_bit < 10'(`SPIREG_PROT_BITS));
  wire [`SPIREG_CHK_W-1:0] chk_now = chk_calc(prot);
  wire mismatch = (chk_r != chk_now) && !upd_r;

  // protected bits are registers 0x00 through 0x43
  always_comb begin
    prot = '0;
    for (int r = 0; r <= `SPIREG_PROT_LAST; r++) begin
      prot[r*8 +: 8] = mem[r];
    end
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  // frame state, bit count and receive shift register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_CMD;
      cnt_r <= 3'h0;
      rx_r <= 7'h00;
    end else if (cs_hi) begin
      st_r <= ST_CMD;
      cnt_r <= 3'h0;
    end else if (sclk_rise) begin
      cnt_r <= cnt_r + 3'h1;
      rx_r <= rx_byte[6:0];
      if (byte_done) begin
        st_r <= st_nxt;
      end
    end
  end

  // next state once a whole byte has arrived
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_CMD: begin
        if (is_wr || is_rd) begin
          st_nxt = ST_ADDR;
        end else if (is_fifo) begin
          st_nxt = ST_FIFO;
        end else begin
          st_nxt = ST_IGNORE;
        end
      end
      ST_ADDR: begin
        st_nxt = cmd_wr_r ? ST_WDATA : ST_RDATA;
      end
      default: begin
        st_nxt = st_r;
      end
    endcase
  end

  // command kind, kept for the address byte
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_wr_r <= 1'b0;
    end else if (cmd_done) begin
      cmd_wr_r <= is_wr;
    end
  end

  // register address: start value, then one up per data byte
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addr_r <= 7'h00;
    end else if (addr_done) begin
      addr_r <= rx_addr;
    end else if (data_done) begin
      addr_r <= addr_inc;
    end
  end

  // ---------------------------------------------------------------
  // serial data out
  // ---------------------------------------------------------------
  // load on a byte boundary, shift after each falling clock edge except the one that ends a byte
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_r <= 8'h00;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else if (cs_hi) begin
      miso_oe <= 1'b0;
    end else if (tx_load) begin
      tx_r <= tx_val;
      miso <= tx_val[7];
      miso_oe <= 1'b1;
    end else if (shift_ok) begin
      tx_r <= {tx_r[6:0], 1'b0};
      miso <= tx_r[6];
    end
  end

  // ---------------------------------------------------------------
  // fifo streaming
  // ---------------------------------------------------------------
  // sample latch, byte half and pop strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      samp_r <= 8'h00;
      half_r <= 1'b0;
      fifo_pop <= 1'b0;
    end else begin
      fifo_pop <= fifo_load && fifo_valid;
      if (cs_hi) begin
        half_r <= 1'b0;
      end else if (fifo_load) begin
        samp_r <= fifo_word[7:0];
        half_r <= 1'b1;
      end else if (fifo_lo) begin
        half_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // register file and upset check
  // ---------------------------------------------------------------
  // writes land here, the upset hook flips one protected bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `SPIREG_NREG; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (wr_en) begin
      mem[addr_r] <= rx_byte;
    end else if (seu_ok) begin
      mem[seu_bit[9:3]][seu_bit[2:0]] <=
        ~mem[seu_bit[9:3]][seu_bit[2:0]];
    end
  end

  // check bits follow a write one cycle later; set wins over clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      chk_r <= '0;
      upd_r <= 1'b0;
      reg_err <= 1'b1;
    end else begin
      upd_r <= wr_en;
      if (upd_r) begin
        chk_r <= chk_now;
      end
      if (mismatch) begin
        reg_err <= 1'b1;
      end else if (wr_data) begin
        reg_err <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // a write byte followed by its check bit refresh
  sequence s_wr_refresh;
    wr_en ##1 upd_r;
  endsequence

  // one pop, then a quiet cycle
  sequence s_pop_once;
    fifo_pop ##1 !fifo_pop;
  endsequence

  a_chk_refresh: assert property (
    @(posedge core_clk) disable iff (!nrst)
    s_wr_refresh |=> (chk_r == $past(chk_now)))
    else $error("check bits not refreshed after write");
  a_pop_pulse: assert property (
    @(posedge core_clk) disable iff (!nrst)
    fifo_pop |-> s_pop_once)
    else $error("fifo pop longer than one cycle");
  a_cs_release: assert property (
    @(posedge core_clk) disable iff (!nrst)
    cs_hi |=> (st_r == ST_CMD) && !miso_oe)
    else $error("frame not ended by chip select");
  a_write_quiet: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (st_r == ST_WDATA) |-> !miso_oe)
    else $error("data out driven during write");
  a_ignore_quiet: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (st_r == ST_IGNORE) |-> !miso_oe)
    else $error("data out driven after unknown command");
  a_err_set: assert property (
    @(posedge core_clk) disable iff (!nrst)
    mismatch |=> reg_err)
    else $error("integrity flag missed a mismatch");
  a_err_clear: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (wr_data && !mismatch) |=> !reg_err)
    else $error("integrity flag kept after write");
  a_addr_step: assert property (
    @(posedge core_clk) disable iff (!nrst)
    data_done |=> (addr_r == $past(addr_inc)))
    else $error("register address did not step");
endmodule

// file: sim/spireg_host.sv
// mode 0 spi master model for the register port
module spireg_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: clock low, deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // frame edge with margin on both sides
  task automatic sel(input logic v);
    #80 cs_n = v;
    #80;
  endtask
  // one byte msb first, captured on the rising clock
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #80 sclk = 1'b1;
      rx[i] = miso;
      #80 sclk = 1'b0;
    end
    mosi = ~mosi; // no stale bit on the idle line
  endtask
endmodule

// file: sim/tb_top.sv
// self-checking bench of the serial register port
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
    $display("BAD %0t got %h", $time, a); end end
  logic core_clk = 1'b0, nrst = 1'b0, miso, miso_oe, keep = 1'b0;
  logic fifo_valid = 1'b0, fifo_pop, seu_inject = 1'b0, reg_err, pin;
  logic oe_hi = 1'b0;
  logic [15:0] fifo_data = 16'h0000;
  logic [9:0] seu_bit = 10'h000;
  logic [7:0] rx;
  wire sclk, cs_n, mosi;
  int fails = 0, compares = 0, pops = 0;
  // clock and the keeper on the data out line
  initial forever #5 core_clk = ~core_clk;
  assign pin = miso_oe ? miso : keep;
  // keeper, output enable and pop monitors
  always @(posedge core_clk) begin
    if (miso_oe === 1'b1) keep <= miso;
    if (miso_oe === 1'b1) oe_hi <= 1'b1;
    if (fifo_pop === 1'b1) pops <= pops + 1;
  end
  spireg_host spireg_host_inst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(pin));
  spireg_port spireg_port_inst (.core_clk(core_clk), .nrst(nrst),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .fifo_data(fifo_data), .fifo_valid(fifo_valid), .fifo_pop(fifo_pop),
    .seu_inject(seu_inject), .seu_bit(seu_bit), .reg_err(reg_err));
  // four-byte frame, returns the last three bytes received
  task automatic frame(input logic [7:0] c, a, d0, d1,
    output logic [23:0] r);
    oe_hi = 1'b0;
    spireg_host_inst.sel(1'b0);
    spireg_host_inst.xfer(c, rx);
    spireg_host_inst.xfer(a, r[23:16]);
    spireg_host_inst.xfer(d0, r[15:8]);
    spireg_host_inst.xfer(d1, r[7:0]);
    spireg_host_inst.sel(1'b1);
    repeat (20) @(negedge core_clk);
  endtask
  task automatic stop_test;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    fails++;
    stop_test;
  end
  // scenarios in order
  initial begin
    logic [23:0] r;
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK(reg_err, 1'b1)
    frame(8'h0A, 8'h05, 8'h11, 8'h22, r);
    `CHK(oe_hi, 1'b0)
    `CHK(reg_err, 1'b0)
    frame(8'h0B, 8'h05, 8'h00, 8'h00, r);
    `CHK(r[15:0], 16'h1122)
    `CHK(oe_hi, 1'b1)
    `CHK(miso_oe, 1'b0)
    frame(8'h0B, 8'h85, 8'h00, 8'h00, r);
    `CHK(r[15:0], 16'h1122)
    frame(8'h3C, 8'h05, 8'h00, 8'h00, r);
    `CHK(oe_hi, 1'b0)
    fifo_data = 16'hBEEF;
    fifo_valid = 1'b1;
    frame(8'h0D, 8'h00, 8'h00, 8'h00, r);
    `CHK(r[23:8], 16'hBEEF)
    `CHK(r[7:0], 8'hBE)
    `CHK(pops, 2)
    seu_bit = 10'h003;
    seu_inject = 1'b1;
    @(negedge core_clk);
    seu_inject = 1'b0;
    repeat (20) @(negedge core_clk);
    `CHK(reg_err, 1'b1)
    frame(8'h0B, 8'h0B, 8'h00, 8'h00, r);
    `CHK(r[15:0], 16'h8000)
    stop_test;
  end
endmodule
